// >>> ppcl_assertions.sv
`timescale 1ns/1ps
module ppcl_checker
	import ppcl_pkg::*;
#(
	parameter int STATUS_LOW_CYCLES = 20,
	parameter int INIT_OSC_CYCLES   = 30
) (
	// Clock and reset
	input wire logic              clock,
	input wire logic              rst,
	// Pins
	input wire logic              cfg_request_n,
	input wire logic              cfg_state_n_out,
	input wire logic              cfg_state_n_oe,
	input wire logic              load_complete,
	input wire logic              user_mode,
	// Word stream
	input wire logic              word_valid,
	input wire logic [DATA_W-1:0] word_data,
	input wire logic              word_ready
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [TMR_W-1:0] low_cnt;  // Cycles status held low
	logic [TMR_W-1:0] done_cnt; // Cycles since completion
	// Status low timer
	always_ff @(posedge clock) begin
		low_cnt <= (rst || !cfg_state_n_oe) ? '0 : low_cnt + 1'b1;
	end
	// Completion timer
	always_ff @(posedge clock) begin
		done_cnt <= (rst || !load_complete) ? '0 : done_cnt + 1'b1;
	end
	a_oe_on_request: assert property (
		$fell(cfg_request_n) |-> ##[1:150] cfg_state_n_oe)
		else $error("status pin not pulled low after request");
	a_done_cleared: assert property (
		$fell(cfg_request_n) |-> ##[1:150] !load_complete)
		else $error("completion not cleared after request");
	a_status_pulse: assert property (
		$fell(cfg_state_n_oe) |-> low_cnt >= STATUS_LOW_CYCLES - 1)
		else $error("status low pulse too short");
	a_open_drain: assert property (
		cfg_state_n_oe |-> !cfg_state_n_out)
		else $error("status pin driven high");
	a_held_request: assert property (
		!cfg_request_n [*8] |=> cfg_state_n_oe && !user_mode)
		else $error("device active while request held low");
	a_release_cause: assert property (
		$fell(cfg_state_n_oe) |-> cfg_request_n && $past(cfg_request_n))
		else $error("status released while request low");
	a_init_delay: assert property (
		$rose(user_mode) |-> load_complete &&
			done_cnt >= INIT_OSC_CYCLES - 1)
		else $error("user mode entered too early");
	a_word_hold: assert property (
		word_valid && !word_ready |=> word_valid && $stable(word_data))
		else $error("stream word dropped or changed while stalled");
endmodule
bind ppcl_loader ppcl_checker #(
	.STATUS_LOW_CYCLES(STATUS_LOW_CYCLES),
	.INIT_OSC_CYCLES  (INIT_OSC_CYCLES)
) u_check (
	.clock          (clock),
	.rst            (rst),
	.cfg_request_n  (cfg_request_n),
	.cfg_state_n_out(cfg_state_n_out),
	.cfg_state_n_oe (cfg_state_n_oe),
	.load_complete  (load_complete),
	.user_mode      (user_mode),
	.word_valid     (word_valid),
	.word_data      (word_data),
	.word_ready     (word_ready)
);

// >>> ppcl_fifo.sv
`timescale 1ns/1ps
module ppcl_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];   // Storage flops
	logic [PTR_W-1:0] wr_ptr;        // Next slot to fill
	logic [PTR_W-1:0] rd_ptr;        // Next slot to drain
	logic [PTR_W:0]   count;         // Words held in storage
	logic             push;          // Word accepted
	logic             pop;           // Word moved to output stage

	assign push = in_valid && in_ready;
	assign pop  = (count != '0) && (!out_valid || out_ready);

	// Storage write
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers, fill level and honest full flag
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			count    <= '0;
			in_ready <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= PTR_W'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= PTR_W'(rd_ptr + 1'b1);
			end
			count    <= (PTR_W+1)'(count + push - pop);
			in_ready <= ((PTR_W+1)'(count + push - pop)) != DEPTH;
		end
	end

	// Registered output stage
	always_ff @(posedge clock) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data  <= mem[rd_ptr];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

endmodule

// >>> ppcl_host.sv
`timescale 1ns/1ps
module ppcl_host
	import ppcl_pkg::*;
(
	// Clock
	input  wire logic              clock,
	// Configuration pins
	output logic                   cfg_request_n,
	input  wire logic              cfg_state_n,
	output logic                   load_clock,
	output logic      [DATA_W-1:0] load_data,
	output logic                   user_init_clock
);
	int uc = 0; // User clock phase count
	initial begin
		cfg_request_n = 1'b1;
		load_clock = 1'b0;
		load_data = '0;
		user_init_clock = 1'b0;
	end
	// Free-running user clock, 80 ns period
	always @(posedge clock) begin
		uc = (uc == 9) ? 0 : uc + 1;
		if (uc == 0) begin
			user_init_clock <= ~user_init_clock;
		end
	end
	// Idle for n system cycles
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Request pulse, then watch status pin under a bound
	task automatic restart(output bit ok);
		ok = 1'b0;
		cfg_request_n <= 1'b0;
		wait_cyc(500);
		cfg_request_n <= 1'b1;
		for (int i = 0; i < 20000 && !ok; i++) begin
			wait_cyc(1);
			ok = cfg_state_n;
		end
		wait_cyc(500);
	endtask
	// One word over n load clock periods of 80 ns
	task automatic send(input logic [DATA_W-1:0] w, input int n);
		load_data <= w;
		for (int e = 0; e < n; e++) begin
			wait_cyc(10);
			load_clock <= 1'b1;
			wait_cyc(10);
			load_clock <= 1'b0;
		end
		wait_cyc(1);
		load_data <= ~w; // Hold over, lines show stale inverse
		wait_cyc(1);
	endtask
endmodule

// >>> ppcl_loader.sv
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module ppcl_loader
	import ppcl_pkg::*;
#(
	parameter int STATUS_LOW_CYCLES = STATUS_LOW_CYC,
	parameter int INIT_OSC_CYCLES   = INIT_OSC_CYC,
	parameter int USER_INIT_EDGES   = USER_INIT_CYCLES
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// Configuration pins
	input  wire logic              cfg_request_n,
	input  wire logic              cfg_state_n_in,
	output logic                   cfg_state_n_out,
	output logic                   cfg_state_n_oe,
	output logic                   load_complete,
	input  wire logic              load_clock,
	input  wire logic [DATA_W-1:0] load_data,
	input  wire logic              user_init_clock,
	// Configuration word stream
	output logic                   word_valid,
	output logic      [DATA_W-1:0] word_data,
	input  wire logic              word_ready,
	// Device state
	output logic                   user_mode,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	output logic      [31:0]       reg_rdata
);

	// Ratio decode from the feature enables
	function automatic logic [3:0] word_ratio(input logic decomp,
		input logic secure);
		if (decomp) begin
			word_ratio = RATIO_DECOMP;
		end else if (secure) begin
			word_ratio = RATIO_SECURE;
		end else begin
			word_ratio = RATIO_PLAIN;
		end
	endfunction

	// One processing round applied on each extra edge when secure
	function automatic logic [DATA_W-1:0] mix_round(
		input logic [DATA_W-1:0] w, input logic [DATA_W-1:0] k);
		mix_round = {w[DATA_W-2:0], w[DATA_W-1]} ^ k;
	endfunction

	// Pin synchronisers
	logic              req_s1, req_s2;       // Request pin
	logic              st_s1, st_s2;         // Status pin readback
	logic              lck_s1, lck_s2;       // Load clock
	logic              lck_d;                // Load clock, one later
	logic              uck_s1, uck_s2;       // User init clock
	logic              uck_d;                // User clock, one later
	logic [DATA_W-1:0] dat_s1, dat_s2;       // Data bus
	logic              lck_rise;             // Load clock rising edge
	logic              uck_rise;             // User clock rising edge

	// Software registers
	logic [4:0]        ctrl;                 // Feature enables and width
	logic [DATA_W-1:0] key;                  // Descramble key
	logic [31:0]       image_words;          // Words in the image

	// Sequencer
	ppcl_state_t       state;                // Present state
	ppcl_state_t       next_state;           // Next state
	logic [TMR_W-1:0]  timer;                // Shared delay counter
	logic [31:0]       word_count;           // Words delivered
	logic              load_error;           // Overflow seen
	logic [3:0]        edge_idx;             // Edge within word group
	logic [DATA_W-1:0] pend;                 // Word being processed
	logic [DATA_W-1:0] sampled;              // Width-masked data
	logic [3:0]        ratio;                // Active ratio
	logic              last_edge;            // Final edge of group
	logic              push;                 // Word offered to FIFO
	logic [DATA_W-1:0] push_data;            // Word offered
	logic              fifo_ready;           // FIFO has room
	logic              req_fall;             // Request now low

	assign ratio     = word_ratio(ctrl[CTRL_DECOMP_BIT],
		ctrl[CTRL_SECURE_BIT]);
	assign lck_rise  = lck_s2 && !lck_d;
	assign uck_rise  = uck_s2 && !uck_d;
	assign req_fall  = !req_s2;
	assign last_edge = edge_idx == (ratio - 4'h1);
	assign push      = (state == ST_LOAD) && lck_rise && last_edge;

	// Width select keeps only the lines in use
	always_comb begin
		case (ctrl[CTRL_WIDTH_LSB +: 2])
			WIDTH_8:  sampled = {24'h000000, dat_s2[7:0]};
			WIDTH_16: sampled = {16'h0000, dat_s2[15:0]};
			default:  sampled = dat_s2;
		endcase
	end

	// Word leaving processing; with ratio 1 it is the fresh sample
	always_comb begin
		if (ratio == RATIO_PLAIN) begin
			push_data = sampled;
		end else if (ctrl[CTRL_SECURE_BIT]) begin
			push_data = mix_round(pend, key);
		end else begin
			push_data = pend;
		end
	end

	// Two-flop synchronisers on every pin input
	always_ff @(posedge clock) begin
		if (rst) begin
			req_s1 <= 1'b1;
			req_s2 <= 1'b1;
			st_s1  <= 1'b1;
			st_s2  <= 1'b1;
			lck_s1 <= 1'b0;
			lck_s2 <= 1'b0;
			lck_d  <= 1'b0;
			uck_s1 <= 1'b0;
			uck_s2 <= 1'b0;
			uck_d  <= 1'b0;
			dat_s1 <= '0;
			dat_s2 <= '0;
		end else begin
			req_s1 <= cfg_request_n;
			req_s2 <= req_s1;
			st_s1  <= cfg_state_n_in;
			st_s2  <= st_s1;
			lck_s1 <= load_clock;
			lck_s2 <= lck_s1;
			lck_d  <= lck_s2;
			uck_s1 <= user_init_clock;
			uck_s2 <= uck_s1;
			uck_d  <= uck_s2;
			dat_s1 <= load_data;
			dat_s2 <= dat_s1;
		end
	end

	// Register writes
	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl        <= CTRL_RESET;
			key         <= '0;
			image_words <= '0;
		end else if (reg_write) begin
			case (reg_addr)
				REG_CTRL:  ctrl        <= reg_wdata[4:0];
				REG_KEY:   key         <= reg_wdata;
				REG_IMAGE: image_words <= reg_wdata;
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end
	end

	// Register reads, data in the following cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_read) begin
			case (reg_addr)
				REG_CTRL:   reg_rdata <= {27'h0000000, ctrl};
				REG_KEY:    reg_rdata <= key;
				REG_IMAGE:  reg_rdata <= image_words;
				REG_STATUS: reg_rdata <= {25'h0000000, load_error,
					user_mode, load_complete, state};
				REG_WORDS:  reg_rdata <= word_count;
				default:    reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// Next state
	always_comb begin
		next_state = state;
		if (req_fall) begin
			next_state = ST_RESET;
		end else begin
			case (state)
				ST_RESET: begin
					// Held low for the minimum pulse
					if (timer >= TMR_W'(STATUS_LOW_CYCLES - 1)) begin
						next_state = ST_RELEASE;
					end
				end
				ST_RELEASE: begin
					// Wait while anyone holds the status pin low
					if (st_s2) begin
						next_state = ST_LOAD;
					end
				end
				ST_LOAD: begin
					if (push && !fifo_ready) begin
						next_state = ST_ERROR;
					end else if (push &&
						word_count + 32'h1 >= image_words) begin
						next_state = ctrl[CTRL_USRCLK_BIT] ?
							ST_INIT_DLY : ST_INIT_OSC;
					end
				end
				ST_INIT_OSC: begin
					if (timer >= TMR_W'(INIT_OSC_CYCLES - 1)) begin
						next_state = ST_USER;
					end
				end
				ST_INIT_DLY: begin
					if (timer >= TMR_W'(CU_DLY_CYC - 1)) begin
						next_state = ST_INIT_USR;
					end
				end
				ST_INIT_USR: begin
					if (uck_rise &&
						timer >= TMR_W'(USER_INIT_EDGES - 1)) begin
						next_state = ST_USER;
					end
				end
				ST_USER:  next_state = ST_USER;
				ST_ERROR: next_state = ST_ERROR;
				default:  next_state = ST_RESET;
			endcase
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	// Shared timer: cycles, or user clock edges while counting those
	always_ff @(posedge clock) begin
		if (rst || next_state != state) begin
			timer <= '0;
		end else if (state == ST_INIT_USR) begin
			if (uck_rise) begin
				timer <= TMR_W'(timer + 1'b1);
			end
		end else if (timer != '1) begin
			timer <= TMR_W'(timer + 1'b1);
		end
	end

	// Word grouping: first edge latches, later edges process when secure
	always_ff @(posedge clock) begin
		if (rst || state != ST_LOAD) begin
			edge_idx <= '0;
			pend     <= '0;
		end else if (lck_rise) begin
			if (last_edge) begin
				edge_idx <= '0;
			end else begin
				edge_idx <= 4'(edge_idx + 4'h1);
			end
			if (edge_idx == 4'h0) begin
				pend <= sampled;
			end else if (ctrl[CTRL_SECURE_BIT]) begin
				pend <= mix_round(pend, key);
			end
		end
	end

	// Delivered word count
	always_ff @(posedge clock) begin
		if (rst || req_fall) begin
			word_count <= '0;
		end else if (push && fifo_ready) begin
			word_count <= word_count + 32'h1;
		end
	end

	// Overflow flag; a fresh overflow wins over the restart clear
	always_ff @(posedge clock) begin
		if (rst) begin
			load_error <= 1'b0;
		end else if (push && !fifo_ready) begin
			load_error <= 1'b1;
		end else if (req_fall) begin
			load_error <= 1'b0;
		end
	end

	// Pin drivers: status pulled low only, completion and user mode
	always_ff @(posedge clock) begin
		if (rst) begin
			cfg_state_n_out <= 1'b0;
			cfg_state_n_oe  <= 1'b1;
			load_complete   <= 1'b0;
			user_mode       <= 1'b0;
		end else begin
			cfg_state_n_out <= 1'b0;
			cfg_state_n_oe  <= (next_state == ST_RESET) ||
				(next_state == ST_ERROR);
			load_complete   <= (next_state == ST_INIT_OSC) ||
				(next_state == ST_INIT_DLY) ||
				(next_state == ST_INIT_USR) ||
				(next_state == ST_USER);
			user_mode       <= next_state == ST_USER;
		end
	end

	// Word buffer toward the core
	ppcl_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (push),
		.in_data   (push_data),
		.in_ready  (fifo_ready),
		.out_valid (word_valid),
		.out_data  (word_data),
		.out_ready (word_ready)
	);

endmodule

// >>> ppcl_pkg.sv
package ppcl_pkg;

	// Clock of the block, in picoseconds per cycle
	localparam int CLK_PERIOD_PS    = 4000;

	// Printed times, in their own units
	localparam int REQ_TO_LOW_NS    = 600;   // Request fall to pins low, max
	localparam int STATUS_LOW_US    = 268;   // Status low pulse, min
	localparam int INIT_OSC_US      = 175;   // Complete to user mode, min
	localparam int LOAD_CLK_MAX_MHZ = 125;   // Fastest load clock
	localparam int CU_DLY_PERIODS   = 4;     // Max load clock periods
	localparam int USER_INIT_CYCLES = 8576;  // User clock periods to start

	// Derived cycle counts (least and CU_DLY_CYC round up, longest rounds down)
	localparam int REQ_TO_LOW_CYC   = (REQ_TO_LOW_NS * 1000) / CLK_PERIOD_PS;
	localparam int STATUS_LOW_CYC   =
		(STATUS_LOW_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int INIT_OSC_CYC     =
		(INIT_OSC_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CU_DLY_CYC       =
		(CU_DLY_PERIODS * (1000000 / LOAD_CLK_MAX_MHZ) + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;

	// Counter width for all timers
	localparam int TMR_W            = 20;

	// Data path
	localparam int DATA_W           = 32;
	localparam int FIFO_DEPTH       = 32;

	// Register bus
	localparam int ADDR_W           = 8;
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_KEY    = 8'h04;
	localparam logic [7:0] REG_IMAGE  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_WORDS  = 8'h10;

	// Control register fields
	localparam int CTRL_DECOMP_BIT  = 0;
	localparam int CTRL_SECURE_BIT  = 1;
	localparam int CTRL_USRCLK_BIT  = 2;
	localparam int CTRL_WIDTH_LSB   = 3;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	// Status register fields
	localparam int STAT_STATE_LSB   = 0;
	localparam int STAT_DONE_BIT    = 4;
	localparam int STAT_USER_BIT    = 5;
	localparam int STAT_ERROR_BIT   = 6;

	// Width selections
	localparam logic [1:0] WIDTH_8  = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;

	// Load clock to data word ratios
	localparam logic [3:0] RATIO_PLAIN  = 4'h1;
	localparam logic [3:0] RATIO_SECURE = 4'h4;
	localparam logic [3:0] RATIO_DECOMP = 4'h8;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_RESET,
		ST_RELEASE,
		ST_LOAD,
		ST_INIT_OSC,
		ST_INIT_DLY,
		ST_INIT_USR,
		ST_USER,
		ST_ERROR
	} ppcl_state_t;

endpackage

// >>> tb.sv
`timescale 1ns/1ps
module tb;
	import ppcl_pkg::*;
	logic              clock = 1'b0;     // System clock
	logic              rst = 1'b1;       // Reset
	logic              req_n, lclk, uclk; // Host pins
	logic [DATA_W-1:0] ldata, word_data; // Pin data, stream word
	logic              st_out, st_oe, done, wvalid, umode;
	logic              word_ready = 1'b0; // Consumer ready
	logic              drain = 1'b0;      // Consumer enabled
	logic [7:0]        reg_addr = '0;
	logic [31:0]       reg_wdata = '0, reg_rdata;
	logic              reg_write = 1'b0, reg_read = 1'b0;
	logic [31:0]       seed = 32'hd0dc0997; // Main random state
	logic [31:0]       stall = 32'hd0dc0997; // Consumer random state
	logic [31:0]       exp_q[$];             // Expected words
	int                error_cnt = 0;
	int                check_count = 0;
	wire               pin = st_oe ? st_out : 1'b1; // Pull-up wire
	always #2 clock = ~clock;
	ppcl_host host (.clock(clock), .cfg_request_n(req_n),
		.cfg_state_n(pin), .load_clock(lclk), .load_data(ldata),
		.user_init_clock(uclk));
	ppcl_loader #(.STATUS_LOW_CYCLES(20), .INIT_OSC_CYCLES(30),
		.USER_INIT_EDGES(10)) dut (.clock(clock), .rst(rst),
		.cfg_request_n(req_n), .cfg_state_n_in(pin),
		.cfg_state_n_out(st_out), .cfg_state_n_oe(st_oe),
		.load_complete(done), .load_clock(lclk), .load_data(ldata),
		.user_init_clock(uclk), .word_valid(wvalid),
		.word_data(word_data), .word_ready(word_ready),
		.user_mode(umode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata));
	// Random step
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Reference word: mode bit0 decompress, bit1 security
	function automatic logic [31:0] model(input logic [31:0] w, k,
		input int m);
		if (m % 3 == 0) w = w & 32'hff;
		if (m % 3 == 1) w = w & 32'hffff;
		if (m >= 2) repeat ((m == 3 ? 8 : 4) - 1) w = {w[30:0], w[31]} ^ k;
		return w;
	endfunction
	// Compare and count
	task automatic check(input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t seen %h expected %h",
				$time, seen, exp);
		end
	endtask
	// Register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask
	// Register read, data in the following cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(posedge clock);
		d = reg_rdata;
	endtask
	// Verdict and end of run
	task automatic print_verdict(input bit hung);
		if (hung) error_cnt++;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Bounded wait for empty queue and, when u is set, user mode
	task automatic settle(input bit u);
		for (int i = 0; i < 20000; i++) begin
			if (exp_q.size() == 0 && (!u || umode === 1'b1)) return;
			@(posedge clock);
		end
		print_verdict(1'b1);
	endtask
	// Consumer with random stalls, in-order compare
	always @(posedge clock) begin
		if (wvalid === 1'b1 && word_ready === 1'b1) begin
			check(word_data, exp_q.size() ? exp_q.pop_front() : '0);
		end
		stall = lfsr(stall);
		word_ready <= drain & stall[0];
	end
	// Main sequence
	initial begin
		logic [31:0] d, k;
		bit ok;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(REG_CTRL, d);
		check(d, 32'h0);
		wr(8'h14, 32'hffffffff);
		rd(8'h14, d);
		check(d, 32'h0);
		drain <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			seed = lfsr(seed);
			k = seed;
			wr(REG_CTRL, {27'h0, 2'(m % 3), m == 3, m >= 2, m % 2 == 1});
			wr(REG_KEY, k);
			wr(REG_IMAGE, 32'h3);
			host.restart(ok);
			check(32'(ok), 32'h1);
			for (int i = 0; i < 3; i++) begin
				seed = lfsr(seed);
				exp_q.push_back(model(seed, k, m));
				host.send(seed, m == 0 ? 1 : (m == 2 ? 4 : 8));
			end
			settle(1'b1);
			check(32'(done), 32'h1);
			rd(REG_STATUS, d);
			check(d, 32'h36);
			rd(REG_WORDS, d);
			check(d, 32'h3);
		end
		wr(REG_CTRL, 32'h0);
		wr(REG_IMAGE, 32'h28);
		drain <= 1'b0;
		host.restart(ok);
		for (int i = 0; i < 34; i++) begin
			seed = lfsr(seed);
			if (i < 33) exp_q.push_back(seed & 32'hff);
			host.send(seed, 1);
		end
		rd(REG_STATUS, d);
		check(d & 32'h4f, 32'h47);
		check(32'(st_oe), 32'h1);
		drain <= 1'b1;
		settle(1'b0);
		host.restart(ok);
		check(32'(ok), 32'h1);
		print_verdict(1'b0);
	end
endmodule
